// [rtl/ucl_cache.sv]
/*
 * unified cache coherence bookkeeping, test registers and line locking.
 * assumes msr and core requests are taken only while their ready is high,
 * and that software keeps its side of the locking protocol.
 */
// Contract
// - line has two sectors, own state each
// - modified means updated, memory not written
// - exclusive write hit: no external write
// - shared write hit: issue external write
// - tag A31-A14, line A13-A5, word A4-A2
// - control write starts op, code bits 1-0
// - 00 flush, 01 write, 10 read, 11 none
// - recency field in control bits 11-8
// - control bits 5-4 select set
// - control bit 23 selects management space
// - test write stores data and tag
// - test read loads state, recency, data
// - flush turns modified into shared
// - locked valid line is private ram
// - indices 03h-05h map the three registers
// - only cold reset clears locked lines
module ucl_cache
	import ucl_pkg::*;
(
	// clock and cold reset
	input  wire logic          sys_clk,
	input  wire logic          reset,
	// model-specific register access
	input  ucl_msr_req_t       msr_req,
	output logic               msr_ready,
	output logic               msr_ack,
	output logic [31:0]        msr_rdata,
	// core cache access
	input  ucl_core_req_t      core_req,
	output logic               core_ready,
	output logic               core_ack,
	output logic               core_hit,
	output logic [31:0]        core_rdata,
	output logic               ext_write_req,
	output logic [31:0]        ext_write_addr,
	output logic [31:0]        ext_write_data,
	// invalidation sources
	input  wire logic          warm_reset_pin,
	input  wire logic          flush_pin_n,
	input  wire logic          invalidate_cache_instr,
	input  wire logic          writeback_invalidate_instr
);
	typedef enum logic [2:0] {
		UCL_S_CLEAR, UCL_S_IDLE, UCL_S_TREAD, UCL_S_FLUSH, UCL_S_INVAL
	} ucl_state_t;

	ucl_state_t   state;
	logic [31:0]  cache_test_data;
	logic [31:0]  cache_test_address;
	logic [31:0]  cache_test_control;
	logic [10:0]  walk;
	logic         walk_done;
	logic         inval_pend;
	logic [2:0]   warm_sync;
	logic [2:0]   flush_sync;
	logic         core_rd_pend;

	ucl_tag_t     tag_rd [UCL_SETS];
	logic [8:0]   rd_idx;
	logic         tw_en;
	logic [1:0]   tw_set;
	logic [8:0]   tw_idx;
	ucl_tag_t     tw_data;
	logic [UCL_DADDR_W-1:0] d_addr;
	logic         d_we;
	logic [31:0]  d_wdata;
	logic [31:0]  d_rdata;

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	logic         msr_fire;
	logic         ctl_wr;
	ucl_op_t      op;
	logic [1:0]   op_set;
	logic         core_fire;
	logic [1:0]   walk_set;
	logic [8:0]   walk_idx;
	ucl_tag_t     walk_old;
	ucl_tag_t     sel_old;

	assign msr_ready  = (state == UCL_S_IDLE) && !inval_pend;
	assign msr_fire   = msr_ready && (msr_req.wr || msr_req.rd);
	assign core_ready = msr_ready && !msr_req.wr && !msr_req.rd;
	assign core_fire  = core_ready && core_req.valid;
	assign ctl_wr     = msr_fire && msr_req.wr && msr_req.index == UCL_IDX_CTRL;
	assign op         = ucl_op_t'(msr_req.wdata[1:0]);
	assign op_set     = msr_req.wdata[UCL_CTL_SET_LSB +: 2];
	assign walk_set   = walk[1:0];
	assign walk_idx   = walk[10:2];
	assign walk_done  = (walk == UCL_WALK_LAST);
	assign walk_old   = tag_rd[walk_set];
	assign sel_old    = tag_rd[op_set];

	// ----------------------------------------------------------------
	// lookup across the four sets
	// ----------------------------------------------------------------
	logic [3:0]   set_hit;
	logic         any_hit;
	logic [1:0]   hit_set;
	logic [3:0]   hit_st;
	ucl_tag_t     hit_old;

	genvar s;
	generate
		for (s = 0; s < UCL_SETS; s++) begin : g_look
			logic [3:0] st;
			assign st = core_req.addr[UCL_SECT_BIT] ? tag_rd[s].st_hi : tag_rd[s].st_lo;
			assign set_hit[s] = (st == UCL_ST_MOD || st == UCL_ST_SHR ||
			                     st == UCL_ST_EXC || st == UCL_ST_LKV) &&
			                    tag_rd[s].tag == core_req.addr[31:UCL_TAG_LSB] &&
			                    tag_rd[s].smm == core_req.smm;
		end
	endgenerate

	always_comb begin
		hit_set = 2'h0;
		for (int i = UCL_SETS - 1; i >= 0; i--) begin
			if (set_hit[i]) begin
				hit_set = 2'(i);
			end
		end
	end

	assign any_hit = |set_hit;
	assign hit_old = tag_rd[hit_set];
	assign hit_st  = core_req.addr[UCL_SECT_BIT] ? hit_old.st_hi : hit_old.st_lo;

	// ----------------------------------------------------------------
	// walk state rewrite
	// ----------------------------------------------------------------
	function automatic logic [3:0] walk_st(input ucl_state_t mode, input logic [3:0] st);
		logic [3:0] r;
		r = st;
		if (mode == UCL_S_CLEAR) begin
			r = UCL_ST_INV;
		end else if (mode == UCL_S_FLUSH && st == UCL_ST_MOD) begin
			r = UCL_ST_SHR;
		end else if (mode == UCL_S_INVAL && st != UCL_ST_LKV && st != UCL_ST_LKI) begin
			r = UCL_ST_INV;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// memory port steering
	// ----------------------------------------------------------------
	always_comb begin
		rd_idx  = core_req.addr[UCL_IDX_LSB +: UCL_IDX_W];
		tw_en   = 1'b0;
		tw_set  = walk_set;
		tw_idx  = walk_idx;
		tw_data = walk_old;
		d_addr  = {hit_set, core_req.addr[UCL_IDX_LSB +: UCL_IDX_W],
		           core_req.addr[UCL_WORD_LSB +: UCL_WORD_W]};
		d_we    = 1'b0;
		d_wdata = core_req.wdata;
		if (state == UCL_S_CLEAR || state == UCL_S_FLUSH || state == UCL_S_INVAL) begin
			rd_idx        = walk_idx;
			tw_en         = 1'b1;
			tw_data.st_hi = walk_st(state, walk_old.st_hi);
			tw_data.st_lo = walk_st(state, walk_old.st_lo);
			if (state == UCL_S_CLEAR) begin
				tw_data = '{tag: '0, smm: 1'b0, st_hi: UCL_ST_INV,
				            st_lo: UCL_ST_INV, recency_bits: 4'h0};
			end
		end else if (msr_fire) begin
			rd_idx = cache_test_address[UCL_IDX_LSB +: UCL_IDX_W];
			d_addr = {op_set, cache_test_address[UCL_IDX_LSB +: UCL_IDX_W],
			          cache_test_address[UCL_WORD_LSB +: UCL_WORD_W]};
			d_wdata = cache_test_data;
			if (ctl_wr && op == UCL_OP_WRITE) begin
				d_we                 = 1'b1;
				tw_en                = 1'b1;
				tw_set               = op_set;
				tw_idx               = rd_idx;
				tw_data              = sel_old;
				tw_data.tag          = cache_test_address[31:UCL_TAG_LSB];
				tw_data.smm          = msr_req.wdata[UCL_CTL_SMM_BIT];
				tw_data.recency_bits = msr_req.wdata[UCL_CTL_REC_LSB +: 4];
				if (cache_test_address[UCL_SECT_BIT]) begin
					tw_data.st_hi = msr_req.wdata[UCL_CTL_ST_LSB +: 4];
				end else begin
					tw_data.st_lo = msr_req.wdata[UCL_CTL_ST_LSB +: 4];
				end
			end
		end else if (core_fire && core_req.we && any_hit) begin
			d_we    = 1'b1;
			tw_set  = hit_set;
			tw_idx  = rd_idx;
			tw_data = hit_old;
			if (hit_st == UCL_ST_EXC) begin
				tw_en = 1'b1;
				if (core_req.addr[UCL_SECT_BIT]) begin
					tw_data.st_hi = UCL_ST_MOD;
				end else begin
					tw_data.st_lo = UCL_ST_MOD;
				end
			end
		end
	end

	ucl_tag_ram u_tag (
		.sys_clk  (sys_clk),
		.rd_idx   (rd_idx),
		.rd_entry (tag_rd),
		.wr_en    (tw_en),
		.wr_set   (tw_set),
		.wr_idx   (tw_idx),
		.wr_entry (tw_data)
	);

	ucl_data_ram u_data (
		.sys_clk (sys_clk),
		.addr    (d_addr),
		.we      (d_we),
		.wdata   (d_wdata),
		.rdata   (d_rdata)
	);

	// ----------------------------------------------------------------
	// invalidation sources
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			warm_sync  <= 3'h0;
			flush_sync <= 3'h7;
		end else begin
			warm_sync  <= {warm_sync[1:0], warm_reset_pin};
			flush_sync <= {flush_sync[1:0], flush_pin_n};
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			inval_pend <= 1'b0;
		end else if ((warm_sync[1] && !warm_sync[2]) || (!flush_sync[1] && flush_sync[2]) ||
		             invalidate_cache_instr || writeback_invalidate_instr) begin
			inval_pend <= 1'b1;
		end else if (state == UCL_S_IDLE) begin
			inval_pend <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state <= UCL_S_CLEAR;
			walk  <= 11'h000;
		end else begin
			unique case (state)
				UCL_S_CLEAR, UCL_S_FLUSH, UCL_S_INVAL: begin
					walk <= walk + 11'h001;
					if (walk_done) begin
						state <= UCL_S_IDLE;
					end
				end
				UCL_S_IDLE: begin
					walk <= 11'h000;
					if (inval_pend) begin
						state <= UCL_S_INVAL;
					end else if (ctl_wr && op == UCL_OP_FLUSH) begin
						state <= UCL_S_FLUSH;
					end else if (ctl_wr && op == UCL_OP_READ) begin
						state <= UCL_S_TREAD;
					end
				end
				UCL_S_TREAD: begin
					state <= UCL_S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// test registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cache_test_data <= UCL_DATA_RST;
		end else if (state == UCL_S_TREAD) begin
			cache_test_data <= d_rdata;
		end else if (msr_fire && msr_req.wr && msr_req.index == UCL_IDX_DATA) begin
			cache_test_data <= msr_req.wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cache_test_address <= UCL_ADDR_RST;
		end else if (msr_fire && msr_req.wr && msr_req.index == UCL_IDX_ADDR) begin
			cache_test_address <= msr_req.wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cache_test_control <= UCL_CTRL_RST;
		end else if (ctl_wr && op != UCL_OP_NONE) begin
			cache_test_control <= msr_req.wdata & UCL_CTL_MASK;
			if (op == UCL_OP_READ) begin
				cache_test_control[UCL_CTL_ST_LSB +: 4] <= cache_test_address[UCL_SECT_BIT] ?
					sel_old.st_hi : sel_old.st_lo;
				cache_test_control[UCL_CTL_REC_LSB +: 4] <= sel_old.recency_bits;
			end
		end
	end

	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			msr_ack   <= 1'b0;
			msr_rdata <= 32'h0000_0000;
		end else begin
			msr_ack <= (msr_fire && !(ctl_wr && (op == UCL_OP_FLUSH || op == UCL_OP_READ))) ||
			           state == UCL_S_TREAD || (state == UCL_S_FLUSH && walk_done);
			if (msr_fire && msr_req.rd) begin
				unique case (msr_req.index)
					UCL_IDX_DATA: msr_rdata <= cache_test_data;
					UCL_IDX_ADDR: msr_rdata <= cache_test_address;
					UCL_IDX_CTRL: msr_rdata <= cache_test_control;
					default:      msr_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			core_ack       <= 1'b0;
			core_hit       <= 1'b0;
			core_rd_pend   <= 1'b0;
			ext_write_req  <= 1'b0;
			ext_write_addr <= 32'h0000_0000;
			ext_write_data <= 32'h0000_0000;
		end else begin
			core_ack      <= core_fire;
			core_hit      <= core_fire && any_hit;
			core_rd_pend  <= core_fire && !core_req.we;
			// shared copies elsewhere must see the write; locked valid lines never do
			ext_write_req <= core_fire && core_req.we && (!any_hit || hit_st == UCL_ST_SHR);
			if (core_fire && core_req.we) begin
				ext_write_addr <= core_req.addr;
				ext_write_data <= core_req.wdata;
			end
		end
	end

	assign core_rdata = core_rd_pend ? d_rdata : 32'h0000_0000;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	logic excl_wr;
	assign excl_wr = core_fire && core_req.we && any_hit && hit_st == UCL_ST_EXC;

	sequence s_read_start;
		ctl_wr && op == UCL_OP_READ && !inval_pend;
	endsequence
	sequence s_read_finish;
		state == UCL_S_TREAD ##1 msr_ack && cache_test_data == $past(d_rdata);
	endsequence

	property p_excl_no_ext;
		excl_wr |=> !ext_write_req;
	endproperty
	a_excl_no_ext: assert property (p_excl_no_ext) else $error("external write on exclusive hit");

	property p_shared_ext;
		core_fire && core_req.we && any_hit && hit_st == UCL_ST_SHR |=> ext_write_req;
	endproperty
	a_shared_ext: assert property (p_shared_ext) else $error("missing external write on shared");

	property p_excl_to_mod;
		excl_wr |-> tw_en && (core_req.addr[4] ? tw_data.st_hi : tw_data.st_lo) == UCL_ST_MOD;
	endproperty
	a_excl_to_mod: assert property (p_excl_to_mod) else $error("exclusive hit not marked modified");

	property p_none_keeps;
		ctl_wr && op == UCL_OP_NONE |=> $stable(cache_test_control) && $stable(cache_test_data);
	endproperty
	a_none_keeps: assert property (p_none_keeps) else $error("no-op changed test registers");

	property p_test_read;
		s_read_start |=> s_read_finish;
	endproperty
	a_test_read: assert property (p_test_read) else $error("test read did not load data");

	property p_flush_shr;
		state == UCL_S_FLUSH && walk_old.st_lo == UCL_ST_MOD |-> tw_en && tw_data.st_lo == UCL_ST_SHR;
	endproperty
	a_flush_shr: assert property (p_flush_shr) else $error("flush left modified sector");

	property p_ctl_reserved;
		(cache_test_control & ~UCL_CTL_MASK) == 32'h0000_0000;
	endproperty
	a_ctl_reserved: assert property (p_ctl_reserved) else $error("undefined control bits set");

	property p_lock_kept;
		state == UCL_S_INVAL && walk_old.st_hi == UCL_ST_LKV |-> tw_data.st_hi == UCL_ST_LKV;
	endproperty
	a_lock_kept: assert property (p_lock_kept) else $error("invalidate dropped locked line");

	property p_flush_start;
		ctl_wr && op == UCL_OP_FLUSH && !inval_pend |=> state == UCL_S_FLUSH && walk == 11'h000;
	endproperty
	a_flush_start: assert property (p_flush_start) else $error("flush did not start");
endmodule

// [rtl/ucl_pkg.sv]
/*
 * shared constants, codes and carriers for the unified cache test and
 * lock block. assumes one core clock and a cold reset from the chip.
 */
package ucl_pkg;
	// ----------------------------------------------------------------
	// geometry and address split
	// ----------------------------------------------------------------
	localparam int UCL_SETS      = 4;
	localparam int UCL_IDX_W     = 9;
	localparam int UCL_TAG_W     = 18;
	localparam int UCL_WORD_W    = 3;
	localparam int UCL_DADDR_W   = 14;
	localparam int UCL_TAG_LSB   = 14;
	localparam int UCL_IDX_LSB   = 5;
	localparam int UCL_WORD_LSB  = 2;
	localparam int UCL_SECT_BIT  = 4;
	localparam int UCL_WALK_W    = 11;
	localparam logic [10:0] UCL_WALK_LAST = 11'h7ff;

	// ----------------------------------------------------------------
	// model-specific register indices and control fields
	// ----------------------------------------------------------------
	localparam logic [7:0]  UCL_IDX_DATA = 8'h03;
	localparam logic [7:0]  UCL_IDX_ADDR = 8'h04;
	localparam logic [7:0]  UCL_IDX_CTRL = 8'h05;
	localparam int UCL_CTL_SMM_BIT = 23;
	localparam int UCL_CTL_ST_LSB  = 16;
	localparam int UCL_CTL_REC_LSB = 8;
	localparam int UCL_CTL_SET_LSB = 4;
	localparam logic [31:0] UCL_CTL_MASK  = 32'h008f0f33;
	localparam logic [31:0] UCL_DATA_RST  = 32'h0000_0000;
	localparam logic [31:0] UCL_ADDR_RST  = 32'h0000_0000;
	localparam logic [31:0] UCL_CTRL_RST  = 32'h0000_0003;

	// ----------------------------------------------------------------
	// valid and coherence state codes, test op codes
	// ----------------------------------------------------------------
	localparam logic [3:0] UCL_ST_MOD = 4'h8;
	localparam logic [3:0] UCL_ST_SHR = 4'h9;
	localparam logic [3:0] UCL_ST_EXC = 4'ha;
	localparam logic [3:0] UCL_ST_INV = 4'h3;
	localparam logic [3:0] UCL_ST_LKV = 4'hc;
	localparam logic [3:0] UCL_ST_LKI = 4'h7;

	typedef enum logic [1:0] {
		UCL_OP_FLUSH = 2'b00,
		UCL_OP_WRITE = 2'b01,
		UCL_OP_READ  = 2'b10,
		UCL_OP_NONE  = 2'b11
	} ucl_op_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [17:0] tag;
		logic        smm;
		logic [3:0]  st_hi;
		logic [3:0]  st_lo;
		logic [3:0]  recency_bits;
	} ucl_tag_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  index;
		logic [31:0] wdata;
	} ucl_msr_req_t;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic        smm;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ucl_core_req_t;
endpackage

// [rtl/ucl_tag_ram.sv]
/*
 * tag memory: one entry per line per set, all sets read at one index.
 * assumes the caller writes at most one set per cycle.
 */
module ucl_tag_ram
	import ucl_pkg::*;
(
	// clock
	input  wire logic              sys_clk,
	// read port
	input  wire logic [8:0]        rd_idx,
	output ucl_tag_t               rd_entry [UCL_SETS],
	// write port
	input  wire logic              wr_en,
	input  wire logic [1:0]        wr_set,
	input  wire logic [8:0]        wr_idx,
	input  ucl_tag_t               wr_entry
);
	genvar s;
	generate
		for (s = 0; s < UCL_SETS; s++) begin : g_set
			ucl_tag_t mem [2**UCL_IDX_W];
			always_ff @(posedge sys_clk) begin
				if (wr_en && wr_set == 2'(s)) begin
					mem[wr_idx] <= wr_entry;
				end
			end
			assign rd_entry[s] = mem[rd_idx];
		end
	endgenerate
endmodule

// [rtl/ucl_data_ram.sv]
/*
 * data memory: one 32-bit word per set, line and word, registered read.
 * assumes a single access per cycle.
 */
module ucl_data_ram
	import ucl_pkg::*;
(
	// clock
	input  wire logic                   sys_clk,
	// access
	input  wire logic [UCL_DADDR_W-1:0] addr,
	input  wire logic                   we,
	input  wire logic [31:0]            wdata,
	output logic      [31:0]            rdata
);
	logic [31:0] mem [2**UCL_DADDR_W];

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// [bench/ucl_cache_tb_top.sv]
/*
 * self-checking bench for ucl_cache: register rows, test write/read,
 * core hits, flush, locking and reset. assumes the rtl files compiled first.
 */
module ucl_cache_tb_top
	import ucl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic        w;
		logic [7:0]  idx;
		logic [31:0] wd;
		logic [31:0] exp;
	} ucl_row_t;

	logic          sys_clk, reset, msr_ready, msr_ack, core_ready, core_ack, core_hit;
	logic          ext_write_req, warm_reset_pin, flush_pin_n;
	logic          invalidate_cache_instr, writeback_invalidate_instr;
	logic [31:0]   msr_rdata, core_rdata, ext_write_addr, ext_write_data, rd, rdt;
	logic [3:0]    st;
	ucl_msr_req_t  msr_req;
	ucl_core_req_t core_req;
	int            mismatches, n_tests;

	// reads first, so the reset values are covered
	localparam ucl_row_t ROWS [13] = '{
		'{1'b0, 8'h03, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h0},
		'{1'b0, 8'h05, 32'h0, 32'h0000_0003},
		'{1'b1, 8'h03, 32'ha5a5_5a5a, 32'h0}, '{1'b0, 8'h03, 32'h0, 32'ha5a5_5a5a},
		'{1'b1, 8'h04, 32'h0000_1234, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h0000_1234},
		'{1'b1, 8'h0a, 32'hdead_beef, 32'h0}, '{1'b0, 8'h0a, 32'h0, 32'h0},
		'{1'b1, 8'h05, 32'hffff_ffff, 32'h0}, '{1'b0, 8'h05, 32'h0, 32'h0000_0003},
		'{1'b1, 8'h05, 32'hff7f_f0d1, 32'h0}, '{1'b0, 8'h05, 32'h0, 32'h000f_0011}
	};

	ucl_cache i_ucl_cache (
		.sys_clk(sys_clk), .reset(reset),
		.msr_req(msr_req), .msr_ready(msr_ready), .msr_ack(msr_ack), .msr_rdata(msr_rdata),
		.core_req(core_req), .core_ready(core_ready), .core_ack(core_ack),
		.core_hit(core_hit), .core_rdata(core_rdata), .ext_write_req(ext_write_req),
		.ext_write_addr(ext_write_addr), .ext_write_data(ext_write_data),
		.warm_reset_pin(warm_reset_pin), .flush_pin_n(flush_pin_n),
		.invalidate_cache_instr(invalidate_cache_instr),
		.writeback_invalidate_instr(writeback_invalidate_instr)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("counts: %0d compares, %0d mismatches", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [31:0] ctl(logic [1:0] op, logic [1:0] s, logic [3:0] t,
		logic [3:0] rc, logic sm);
		return {8'h00, sm, 3'h0, t, 4'h0, rc, 2'h0, s, 2'h0, op};
	endfunction

	// distinct tag per set, line 0x010, word = set
	function automatic logic [31:0] af(int s);
		return {16'h0000, 2'(s + 1), 14'h0200 | 14'(s * 4)};
	endfunction

	// word w of the set 1 test line
	function automatic logic [31:0] lw(int w);
		return (af(1) & 32'hffff_ffe0) + 32'(w * 4);
	endfunction

	task automatic msr(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		tick();
		msr_req = '{w, !w, idx, wd};
		while (!msr_ready && n++ < 3000)
			tick();
		tick();
		msr_req = '0;
		while (!msr_ack && n++ < 6000)
			tick();
		rd = msr_rdata;
		if (n > 6000)
			mismatches++;
	endtask

	task automatic core(input logic w, input logic s, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		tick();
		core_req = '{1'b1, w, s, a, d};
		while (!core_ready && n++ < 3000)
			tick();
		tick();
		core_req = '0;
		while (!core_ack && n++ < 3010)
			tick();
		if (n > 3010)
			mismatches++;
	endtask

	task automatic twr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s,
		input logic [3:0] t, input logic sm);
		msr(1'b1, UCL_IDX_DATA, d);
		msr(1'b1, UCL_IDX_ADDR, a);
		msr(1'b1, UCL_IDX_CTRL, ctl(UCL_OP_WRITE, s, t, {2'h1, s}, sm));
	endtask

	task automatic trd(input logic [31:0] a, input logic [1:0] s, input logic sm);
		msr(1'b1, UCL_IDX_ADDR, a);
		msr(1'b1, UCL_IDX_CTRL, ctl(UCL_OP_READ, s, 4'h0, 4'h0, sm));
		msr(1'b0, UCL_IDX_DATA, 32'h0);
		rdt = rd;
		msr(1'b0, UCL_IDX_CTRL, 32'h0);
		st = rd[19:16];
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		msr_req = '0;
		core_req = '0;
		{invalidate_cache_instr, writeback_invalidate_instr, warm_reset_pin, flush_pin_n} = 4'b0001;
		mismatches = 0;
		n_tests = 0;
		repeat (8) @(posedge sys_clk);
		#1 reset = 1'b0;
		foreach (ROWS[i]) begin
			msr(ROWS[i].w, ROWS[i].idx, ROWS[i].wd);
			if (!ROWS[i].w)
				chk(rd, ROWS[i].exp);
		end
		$display("register rows done");
		for (int s = 0; s < 4; s++)
			twr(af(s), 32'hc0de_0000 + s, 2'(s), UCL_ST_EXC, 1'b0);
		for (int s = 0; s < 4; s++) begin
			trd(af(s), 2'(s), 1'b0);
			chk(rdt, 32'hc0de_0000 + s);
			chk(st, UCL_ST_EXC);
			chk(rd[11:8], {2'h1, 2'(s)});
		end
		$display("set write and read done");
		core(1'b0, 1'b0, af(2), 32'h0);
		chk({core_ack, core_hit, ext_write_req}, 3'b110);
		chk(core_rdata, 32'hc0de_0002);
		core(1'b0, 1'b0, af(2) ^ 32'h8000_0000, 32'h0);
		chk(core_hit, 1'b0);
		core(1'b1, 1'b0, af(0), 32'h1111_1111);
		chk({core_hit, ext_write_req}, 2'b10);
		trd(af(0), 2'd0, 1'b0);
		chk(st, UCL_ST_MOD);
		chk(rdt, 32'h1111_1111);
		twr(af(1), 32'h2, 2'd1, UCL_ST_SHR, 1'b0);
		core(1'b1, 1'b0, af(1), 32'h2222_2222);
		chk({core_hit, ext_write_req}, 2'b11);
		chk(ext_write_addr, af(1));
		chk(ext_write_data, 32'h2222_2222);
		core(1'b1, 1'b0, 32'h0fff_0000, 32'h3333_3333);
		chk({core_hit, ext_write_req}, 2'b01);
		$display("core access done");
		msr(1'b1, UCL_IDX_CTRL, ctl(UCL_OP_FLUSH, 2'd0, 4'h0, 4'h0, 1'b0));
		trd(af(0), 2'd0, 1'b0);
		chk(st, UCL_ST_SHR);
		trd(af(3), 2'd3, 1'b0);
		chk(st, UCL_ST_EXC);
		twr(af(2) + 32'h10, 32'h5, 2'd2, UCL_ST_SHR, 1'b0);
		trd(af(2), 2'd2, 1'b0);
		chk(st, UCL_ST_EXC);
		trd(af(2) + 32'h10, 2'd2, 1'b0);
		chk(st, UCL_ST_SHR);
		chk(rdt, 32'h5);
		$display("flush and sector done");
		twr(af(3), 32'h3, 2'd3, UCL_ST_EXC, 1'b1);
		core(1'b0, 1'b0, af(3), 32'h0);
		chk(core_hit, 1'b0);
		core(1'b0, 1'b1, af(3), 32'h0);
		chk(core_hit, 1'b1);
		chk(core_rdata, 32'h3);
		// one set only, not locked before: fill all eight words, then mark valid
		for (int w = 0; w < 8; w++)
			twr(lw(w), 32'h70 + 32'(w), 2'd1, UCL_ST_LKI, 1'b0);
		twr(lw(1), 32'h71, 2'd1, UCL_ST_LKV, 1'b0);
		twr(lw(5), 32'h75, 2'd1, UCL_ST_LKV, 1'b0);
		for (int w = 0; w < 8; w++) begin
			trd(lw(w), 2'd1, 1'b0);
			chk(rdt, 32'h70 + 32'(w));
			chk(st, UCL_ST_LKV);
		end
		core(1'b1, 1'b0, af(1), 32'h7777_7777);
		chk({core_hit, ext_write_req}, 2'b10);
		// invalidate_cache_instr, writeback_invalidate_instr, warm reset pin, flush pin in turn
		for (int e = 0; e < 4; e++) begin
			twr(af(0), 32'h0, 2'd0, UCL_ST_EXC, 1'b0);
			invalidate_cache_instr = (e == 0);
			writeback_invalidate_instr = (e == 1);
			warm_reset_pin = (e == 2);
			flush_pin_n = (e != 3);
			repeat (e < 2 ? 1 : 4) tick();
			{invalidate_cache_instr, writeback_invalidate_instr, warm_reset_pin, flush_pin_n} = 4'b0001;
			trd(af(0), 2'd0, 1'b0);
			chk(st, UCL_ST_INV);
			trd(af(1), 2'd1, 1'b0);
			chk(st, UCL_ST_LKV);
			chk(rdt, 32'h7777_7777);
		end
		$display("lock and invalidate done");
		reset = 1'b1;
		tick();
		reset = 1'b0;
		chk({msr_ready, core_ready, msr_ack, core_ack}, 4'h0);
		trd(af(1), 2'd1, 1'b0);
		chk(st, UCL_ST_INV);
		$display("cold reset done");
		test_done();
	end

	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		test_done();
	end
endmodule
